// File: shared/idb_pkg.sv
`include "idb_regs.svh"
package idb_pkg;

  typedef logic [`IDB_NUM_REQ-1:0] idb_reqvec_t;

  typedef struct packed {
    logic [`IDB_ADDR_W-1:0]   row;
    logic [`IDB_ADDR_W-1:0]   col;
    logic                     we;
    logic [`IDB_CAS_W-1:0]    be;
    logic [2*`IDB_DATA_W-1:0] wdata;
  } idb_req_t;

  typedef struct packed {
    logic                   ras_n;
    logic [`IDB_ADDR_W-1:0] addr;
    logic                   memory_write_strobe_n;
    logic [`IDB_CAS_W-1:0]  cas_n;
  } idb_dram_t;

  typedef struct packed {
    logic odd_bank_b_out_en_n;
    logic odd_bank_a_out_en_n;
    logic even_bank_b_out_en_n;
    logic even_bank_a_out_en_n;
  } idb_oe_t;

  typedef struct packed {
    logic shared_select_bit1;
    logic ext_pixel_clock_in;
    logic ext_sync_in;
    logic ext_video_in;
  } idb_shared_t;

  typedef enum logic [1:0] {IDB_IDLE, IDB_ACT, IDB_PAGE, IDB_PRE} idb_state_t;

endpackage : idb_pkg

// File: shared/idb_regs.svh
`ifndef IDB_REGS_SVH
`define IDB_REGS_SVH

`define IDB_NUM_REQ     5
`define IDB_ID_W        3
`define IDB_REQ_DISPLAY 3'h0
`define IDB_REQ_HOST    3'h1
`define IDB_REQ_ACCEL   3'h2
`define IDB_REQ_IMAGE   3'h3
`define IDB_REQ_REFRESH 3'h4
`define IDB_ADDR_W      9
`define IDB_DATA_W      32
`define IDB_CAS_W       8

// One tick is one sys_clk, which is half a memory clock period; a column pair spans four ticks.
`define IDB_CLK_MHZ     100
`define IDB_T_RCD_NS    40
`define IDB_T_RP_NS     40
`define IDB_T_RREF_NS   80
`define IDB_CYC(ns)     (((ns) * `IDB_CLK_MHZ + 999) / 1000)
`define IDB_RCD_CYC     4'(`IDB_CYC(`IDB_T_RCD_NS))
`define IDB_RP_CYC      4'(`IDB_CYC(`IDB_T_RP_NS))
`define IDB_RREF_CYC    4'(`IDB_CYC(`IDB_T_RREF_NS))

// Per-tick masks, bit n set means active in tick n of a column pair.
`define IDB_EV_CAS      4'h3
`define IDB_OD_CAS      4'hc
`define IDB_EV_CAS_OE   4'h7
`define IDB_OD_CAS_OE   4'he
`define IDB_EV_OE       4'h6
`define IDB_OD_OE       4'h8
`define IDB_EV_SAMP     4'h8
`define IDB_OD_SAMP     4'h1
`define IDB_EV_CAP      4'h2
`define IDB_EV_CAP_OE   4'h4
`define IDB_OD_CAP      4'h8

`endif

// File: tb/idb_bank_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "idb_regs.svh"
// ==========
// Pin-level checker.
module idb_bank_ctrl_chk (
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  input wire logic                    cas_only_mode,
  input wire logic [`IDB_NUM_REQ-1:0] req_valid,
  input wire logic [`IDB_NUM_REQ-1:0] req_ready,
  input wire idb_pkg::idb_dram_t      dram,
  input wire idb_pkg::idb_oe_t        oe_pin_out,
  input wire idb_pkg::idb_oe_t        oe_pin_oe_n,
  input wire idb_pkg::idb_shared_t    shared_in_q
);
  wire       ev = dram.cas_n[3:0] != 4'hf;
  wire       od = dram.cas_n[7:4] != 4'hf;
  // An enable counts only where the pin is both driven and low.
  wire [3:0] drv = ~oe_pin_oe_n & ~oe_pin_out;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_row; ev || od |-> !dram.ras_n; endproperty
  a_row: assert property (p_row) else $error("cas outside row");
  property p_sep; cas_only_mode |-> !(ev && od); endproperty
  a_sep: assert property (p_sep) else $error("banks overlap");
  property p_ovl; |drv[1:0] |-> ev && od && !cas_only_mode; endproperty
  a_ovl: assert property (p_ovl) else $error("no overlap");
  property p_one; !(|drv[1:0] && |drv[3:2]); endproperty
  a_one: assert property (p_one) else $error("both enabled");
  property p_ab; drv[0] == drv[1] && drv[2] == drv[3]; endproperty
  a_ab: assert property (p_ab) else $error("a b differ");
  property p_pair; drv != 4'h0 |-> (drv[1:0] == 2'b00 || ev) && (drv[3:2] == 2'b00 || od); endproperty
  a_pair: assert property (p_pair) else $error("bad pairing");
  property p_win; req_valid[0] && req_ready != 5'h00 |-> req_ready == 5'h01; endproperty
  a_win: assert property (p_win) else $error("display lost");
  property p_idle; cas_only_mode |-> oe_pin_oe_n == 4'hf; endproperty
  a_idle: assert property (p_idle) else $error("pin driven");
  property p_samp; oe_pin_oe_n != 4'hf |=> ((shared_in_q ^ $past(shared_in_q)) & ~$past(oe_pin_oe_n)) == 4'h0;
  endproperty
  a_samp: assert property (p_samp) else $error("sampled driven pin");
endmodule : idb_bank_ctrl_chk
bind idb_bank_ctrl idb_bank_ctrl_chk u_chk (.sys_clk, .arst_n, .cas_only_mode, .req_valid, .req_ready, .dram,
  .oe_pin_out, .oe_pin_oe_n, .shared_in_q);
`default_nettype wire

// File: tb/idb_dram_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Two interleaved page-mode banks on one data bus.
module idb_dram_model (
  input wire logic               sys_clk,
  input wire logic               use_oe,
  input wire idb_pkg::idb_dram_t dram,
  input wire logic [3:0]         oe_lvl,
  output logic [31:0]            md_in
);
  logic [31:0] last_ff;
  wire rd = dram.memory_write_strobe_n;
  wire ev = rd && dram.cas_n[3:0] != 4'hf && (!use_oe || oe_lvl[1:0] != 2'b11);
  wire od = rd && dram.cas_n[7:4] != 4'hf && (!use_oe || oe_lvl[3:2] != 2'b11);
  // A released bus shows the inverse of its last value, so stale data never looks valid.
  always_comb begin
    md_in = ~last_ff;
    if (ev)
      md_in = {16'he0e0, 7'h00, dram.addr};
    if (od)
      md_in = ev ? 32'hxxxx_xxxx : {16'h0d0d, 7'h00, dram.addr};
  end
  always_ff @(posedge sys_clk) last_ff <= md_in;
endmodule : idb_dram_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "idb_regs.svh"
// ==========
// Self-checking bench.
module testbench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cas_only_mode = 1'b1;
  logic [4:0] req_valid = 5'h00;
  idb_pkg::idb_req_t [4:0] req = '0;
  logic [4:0] req_ready;
  logic rsp_valid, md_oe_n;
  logic [2:0] rsp_id;
  logic [63:0] rsp_rdata;
  logic [31:0] md_in, md_out;
  idb_pkg::idb_dram_t dram;
  idb_pkg::idb_oe_t oe_pin_out, oe_pin_oe_n;
  idb_pkg::idb_shared_t shared_in_q;
  logic [3:0] ext = 4'h0;
  int fails = 0, total_checks = 0, cycles = 0;
  int tk[5], rs[5], ncas, novl, nras, nmd;
  logic [63:0] rv[5];
  logic [31:0] mdv[4];
  logic [8:0] ra;
  logic [7:0] cv;
  // A driven pin shows its enable level, a released one the external input.
  wire [3:0] pin = (oe_pin_oe_n & ext) | (~oe_pin_oe_n & oe_pin_out);
  wire idb_pkg::idb_shared_t oe_pin_in = idb_pkg::idb_shared_t'(pin);
  idb_bank_ctrl DUT (.sys_clk, .arst_n, .cas_only_mode, .req_valid, .req, .req_ready, .rsp_valid, .rsp_id,
    .rsp_rdata, .dram, .md_out, .md_oe_n, .md_in, .oe_pin_out, .oe_pin_oe_n, .oe_pin_in, .shared_in_q);
  idb_dram_model u_mem (.sys_clk, .use_oe(!cas_only_mode), .dram, .oe_lvl(pin), .md_in);
  always #5 sys_clk = ~sys_clk;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done;
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [63:0] pat(input logic [8:0] c);
    pat = {16'h0d0d, 7'h00, c, 16'he0e0, 7'h00, c};
  endfunction : pat
  task automatic put(input int i, input logic [8:0] r, input logic [8:0] c, input logic w,
                     input logic [7:0] b = 8'hff, input logic [63:0] d = 64'h0);
    req[i] = '{row: r, col: c, we: w, be: b, wdata: d};
    req_valid[i] = 1'b1;
  endtask : put
  // Steps whole cycles, retiring taken requests and logging strobe activity.
  task automatic run(input int cyc);
    logic [4:0] take;
    tk = '{default: 0};
    rs = '{default: 0};
    {ncas, novl, nras, nmd} = '0;
    cv = 8'hff;
    ra = 9'h000;
    for (int k = 1; k <= cyc; k++) begin
      #1;
      take = req_valid & req_ready;
      @(negedge sys_clk);
      for (int i = 0; i < 5; i++) begin
        if (take[i]) begin
          req_valid[i] = 1'b0;
          tk[i] = k;
        end
      end
      if (rsp_valid === 1'b1) begin
        rs[rsp_id] = k;
        rv[rsp_id] = rsp_rdata;
      end
      if (nras == 0 && dram.ras_n === 1'b0)
        ra = dram.addr;
      if (dram.cas_n != 8'hff)
        cv = dram.cas_n;
      if (md_oe_n === 1'b0)
        mdv[nmd[1:0]] = md_out;
      ncas += int'(dram.cas_n != 8'hff);
      novl += int'(dram.cas_n[3:0] != 4'hf && dram.cas_n[7:4] != 4'hf);
      nras += int'(dram.ras_n === 1'b0);
      nmd += int'(md_oe_n === 1'b0);
    end
  endtask : run
  task automatic t_miss;
    for (int i = 0; i < 4; i++) begin
      put(i, 9'h010 + 9'(i), 9'h020 + 9'(i), 1'b0);
      run(30);
      chk(rs[i] - tk[i], 9);
      chk(rv[i], pat(9'h020 + 9'(i)));
      chk(ra, 9'h010 + 9'(i));
      chk(ncas, 4);
      chk(novl, 0);
    end
  endtask : t_miss
  task automatic t_prio;
    put(2, 9'h077, 9'h003, 1'b0);
    put(1, 9'h077, 9'h002, 1'b0);
    put(0, 9'h077, 9'h001, 1'b0);
    run(40);
    chk(tk[1] - tk[0], 8);
    chk(tk[2] - tk[1], 4);
    chk(rs[2] - tk[2], 5);
    for (int i = 0; i < 3; i++)
      chk(rv[i], pat(9'(i + 1)));
  endtask : t_prio
  task automatic t_oe;
    cas_only_mode = 1'b0;
    ext = 4'h3;
    put(3, 9'h033, 9'h044, 1'b0);
    run(30);
    chk(rs[3] - tk[3], 9);
    chk(rv[3], pat(9'h044));
    chk(novl, 2);
    chk(shared_in_q, 4'h3);
    put(1, 9'h033, 9'h055, 1'b1, 8'h3c, 64'h1234_5678_9abc_def0);
    run(30);
    chk(nmd, 4);
    chk(rs[1], 0);
    chk(novl, 0);
    chk(cv, 8'hcf);
    chk({mdv[3], mdv[0]}, 64'h1234_5678_9abc_def0);
    chk({mdv[2], mdv[1]}, 64'h1234_5678_9abc_def0);
    put(4, 9'h066, 9'h000, 1'b0);
    run(30);
    chk(ncas, 0);
    chk(nras, 8);
    cas_only_mode = 1'b1;
  endtask : t_oe
  task automatic t_shared;
    ext = 4'ha;
    run(3);
    chk(shared_in_q, 4'ha);
    chk(oe_pin_oe_n, 4'hf);
    ext = 4'h5;
    run(3);
    chk(shared_in_q, 4'h5);
  endtask : t_shared
  initial begin
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    t_miss;
    t_prio;
    t_oe;
    t_shared;
    test_done;
  end
endmodule : testbench
`default_nettype wire

// File: verilog/idb_bank_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "idb_regs.svh"
module idb_bank_ctrl (
  input  wire logic                                       sys_clk,
  input  wire logic                                       arst_n,
  input  wire logic                                       cas_only_mode,
  input  wire logic [`IDB_NUM_REQ-1:0]                    req_valid,
  input  wire idb_pkg::idb_req_t [`IDB_NUM_REQ-1:0]       req,
  output logic [`IDB_NUM_REQ-1:0]                         req_ready,
  output logic                                            rsp_valid,
  output logic [`IDB_ID_W-1:0]                            rsp_id,
  output logic [2*`IDB_DATA_W-1:0]                        rsp_rdata,
  output var idb_pkg::idb_dram_t                          dram,
  output logic [`IDB_DATA_W-1:0]                          md_out,
  output logic                                            md_oe_n,
  input  wire logic [`IDB_DATA_W-1:0]                     md_in,
  output var idb_pkg::idb_oe_t                            oe_pin_out,
  output var idb_pkg::idb_oe_t                            oe_pin_oe_n,
  input  wire idb_pkg::idb_shared_t                       oe_pin_in,
  output var idb_pkg::idb_shared_t                        shared_in_q
);

  // ==========================================================================
  // Arbitration
  // ==========================================================================
  idb_pkg::idb_state_t       state_ff;
  idb_pkg::idb_state_t       nxt_state;
  idb_pkg::idb_req_t         cur_ff;
  logic [`IDB_ID_W-1:0]      cur_id_ff;
  logic [1:0]                ph_ff;
  logic [3:0]                cnt_ff;
  logic [3:0]                nxt_cnt;
  logic [`IDB_ID_W-1:0]      win_id;
  idb_pkg::idb_req_t         win_req;
  logic                      any_req;
  logic                      take;
  logic                      take_page;
  logic                      ph_last;
  logic                      cnt_done;
  logic [3:0]                cnt_lim;

  // Fixed priority: the display fetch is chosen whenever it asks.
  assign win_id = req_valid[0] ? `IDB_REQ_DISPLAY :
                  req_valid[1] ? `IDB_REQ_HOST    :
                  req_valid[2] ? `IDB_REQ_ACCEL   :
                  req_valid[3] ? `IDB_REQ_IMAGE   : `IDB_REQ_REFRESH;
  assign win_req   = req[win_id];
  assign any_req   = |req_valid;
  assign ph_last   = ph_ff == 2'h3;
  // A page stays open while a non-refresh winner hits the same row, so bursts avoid row cycles.
  assign take_page = (state_ff == idb_pkg::IDB_PAGE) && ph_last && any_req &&
                     (win_req.row == cur_ff.row) && (win_id != `IDB_REQ_REFRESH);
  assign take      = ((state_ff == idb_pkg::IDB_IDLE) && any_req) || take_page;
  assign req_ready = take ? idb_pkg::idb_reqvec_t'(1 << win_id) : '0;
  assign cnt_lim   = (state_ff == idb_pkg::IDB_PRE) ? `IDB_RP_CYC :
                     (cur_id_ff == `IDB_REQ_REFRESH) ? `IDB_RREF_CYC : `IDB_RCD_CYC;
  assign cnt_done  = cnt_ff == (cnt_lim - 4'h1);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 4'h1;
    case (state_ff)
      idb_pkg::IDB_IDLE: begin
        nxt_cnt = 4'h0;
        if (any_req) begin
          nxt_state = idb_pkg::IDB_ACT;
        end
      end
      idb_pkg::IDB_ACT: begin
        if (cnt_done) begin
          nxt_cnt   = 4'h0;
          // Refresh is a row-only cycle with no column phase.
          nxt_state = (cur_id_ff == `IDB_REQ_REFRESH) ? idb_pkg::IDB_PRE : idb_pkg::IDB_PAGE;
        end
      end
      idb_pkg::IDB_PAGE: begin
        nxt_cnt = 4'h0;
        if (ph_last && !take_page) begin
          nxt_state = idb_pkg::IDB_PRE;
        end
      end
      idb_pkg::IDB_PRE: begin
        if (cnt_done) begin
          nxt_cnt   = 4'h0;
          nxt_state = idb_pkg::IDB_IDLE;
        end
      end
      default: begin
        nxt_state = idb_pkg::IDB_IDLE;
        nxt_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff  <= idb_pkg::IDB_IDLE;
      cnt_ff    <= 4'h0;
      ph_ff     <= 2'h0;
      cur_ff    <= '0;
      cur_id_ff <= `IDB_REQ_DISPLAY;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ph_ff    <= (state_ff == idb_pkg::IDB_PAGE) ? ph_ff + 2'h1 : 2'h0;
      if (take) begin
        cur_ff    <= win_req;
        cur_id_ff <= win_id;
      end
    end
  end

  // ==========================================================================
  // Strobe and data timing
  // ==========================================================================
  logic                      in_page;
  logic                      oe_mode;
  logic                      rd;
  logic [3:0]                ev_mask;
  logic [3:0]                od_mask;
  logic                      ev_low;
  logic                      od_low;
  logic                      drive_ev;
  logic                      drive_od;
  logic                      nxt_cap_ev;
  logic                      nxt_cap_od;
  logic                      cap_ev_ff;
  logic                      cap_od_ff;
  logic [`IDB_ID_W-1:0]      pend_id_ff;
  logic [`IDB_DATA_W-1:0]    rd_lo_ff;
  idb_pkg::idb_dram_t        nxt_dram;
  idb_pkg::idb_oe_t          nxt_oe_out;
  idb_pkg::idb_oe_t          nxt_oe_en_n;
  logic [3:0]                ev_samp_m;
  logic [3:0]                od_samp_m;
  logic [3:0]                ev_oe_m;
  logic [3:0]                od_oe_m;
  logic [3:0]                ev_cap_m;
  logic [3:0]                od_cap_m;
  logic [3:0]                nxt_shared;

  assign in_page = state_ff == idb_pkg::IDB_PAGE;
  assign oe_mode = !cas_only_mode;
  assign rd      = in_page && !cur_ff.we;
  // Writes keep the non-overlapping strobes because the banks share the data bus.
  assign ev_mask = (oe_mode && rd) ? `IDB_EV_CAS_OE : `IDB_EV_CAS;
  assign od_mask = (oe_mode && rd) ? `IDB_OD_CAS_OE : `IDB_OD_CAS;
  assign ev_low  = in_page && ev_mask[ph_ff];
  assign od_low  = in_page && od_mask[ph_ff];

  assign nxt_dram.ras_n = !((state_ff == idb_pkg::IDB_ACT) || in_page);
  assign nxt_dram.addr  = in_page ? cur_ff.col : cur_ff.row;
  assign nxt_dram.memory_write_strobe_n = !(in_page && cur_ff.we);
  // Upper strobe lanes address the odd bank, lower lanes the even bank.
  assign nxt_dram.cas_n = ~(cur_ff.be & {{4{od_low}}, {4{ev_low}}});

  // Tick masks live in named wires so that the current tick can index them.
  assign ev_samp_m = `IDB_EV_SAMP;
  assign od_samp_m = `IDB_OD_SAMP;
  assign ev_oe_m   = `IDB_EV_OE;
  assign od_oe_m   = `IDB_OD_OE;
  assign ev_cap_m  = oe_mode ? `IDB_EV_CAP_OE : `IDB_EV_CAP;
  assign od_cap_m  = `IDB_OD_CAP;

  // Pins are released outside the column phase and in each bank's precharge tick.
  assign drive_ev = oe_mode && in_page && !ev_samp_m[ph_ff];
  assign drive_od = oe_mode && in_page && !od_samp_m[ph_ff];
  assign nxt_oe_out.even_bank_a_out_en_n = !(rd && ev_oe_m[ph_ff]);
  assign nxt_oe_out.even_bank_b_out_en_n = !(rd && ev_oe_m[ph_ff]);
  assign nxt_oe_out.odd_bank_a_out_en_n  = !(rd && od_oe_m[ph_ff]);
  assign nxt_oe_out.odd_bank_b_out_en_n  = !(rd && od_oe_m[ph_ff]);
  assign nxt_oe_en_n = {!drive_od, !drive_od, !drive_ev, !drive_ev};

  assign nxt_cap_ev = rd && ev_cap_m[ph_ff];
  assign nxt_cap_od = rd && od_cap_m[ph_ff];

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dram        <= '{ras_n: 1'b1, addr: '0, memory_write_strobe_n: 1'b1, cas_n: '1};
      md_out      <= '0;
      md_oe_n     <= 1'b1;
      oe_pin_out  <= '1;
      oe_pin_oe_n <= '1;
      cap_ev_ff   <= 1'b0;
      cap_od_ff   <= 1'b0;
      pend_id_ff  <= `IDB_REQ_DISPLAY;
    end else begin
      dram        <= nxt_dram;
      md_out      <= ph_ff[1] ? cur_ff.wdata[2*`IDB_DATA_W-1:`IDB_DATA_W] : cur_ff.wdata[`IDB_DATA_W-1:0];
      md_oe_n     <= !(in_page && cur_ff.we);
      oe_pin_out  <= nxt_oe_out;
      oe_pin_oe_n <= nxt_oe_en_n;
      cap_ev_ff   <= nxt_cap_ev;
      cap_od_ff   <= nxt_cap_od;
      if (nxt_cap_od) begin
        pend_id_ff <= cur_id_ff;
      end
    end
  end

  // ==========================================================================
  // Read return and shared input sampling
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_lo_ff  <= '0;
      rsp_valid <= 1'b0;
      rsp_id    <= `IDB_REQ_DISPLAY;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= cap_od_ff;
      if (cap_ev_ff) begin
        rd_lo_ff <= md_in;
      end
      if (cap_od_ff) begin
        rsp_rdata <= {md_in, rd_lo_ff};
        rsp_id    <= pend_id_ff;
      end
    end
  end

  // A pin is sampled only during a whole tick in which our driver is off.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_shared
      assign nxt_shared[gi] = oe_pin_oe_n[gi] ? oe_pin_in[gi] : shared_in_q[gi];
    end
  endgenerate

  // One register for all four pins keeps a single driver on the sampled word.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shared_in_q <= '0;
    end else begin
      shared_in_q <= nxt_shared;
    end
  end

endmodule : idb_bank_ctrl
`default_nettype wire
